// >>> design/spr_device.sv
/*
 Register port end: a slave that gives the serial master access to 128
 eight-bit registers, plus a local write strobe and a local read port.
 Assumes every link pin is asynchronous to core_clk and that the master
 keeps sclk at most half the core clock rate. All registers clear to zero
 on reset. There is no decode of register kinds: a later write to one
 location simply replaces an earlier one, whatever its spacing.
*/
`timescale 1ns/1ps
`default_nettype none
module spr_device (
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  spr_if.device                           link,
  input  wire logic [spr_pkg::ADDR_W-1:0] lookAddr,
  output logic      [spr_pkg::DATA_W-1:0] lookData,
  output logic                            wrStrobe,
  output logic      [spr_pkg::ADDR_W-1:0] wrAddr,
  output logic      [spr_pkg::DATA_W-1:0] wrData
);
  import spr_pkg::*;

  // Port sequencer: idle while deselected, framing while selected, then
  // done until the select rises again.
  typedef enum logic [1:0] {DevIdle, DevFrame, DevDone} spr_dev_e;

  // All state of the port in one record: the synchroniser stages (the
  // third stage of clock and select feeds the edge finders), the frame
  // sequencer, the serial output side, the register space and the local
  // ports. Keeping the register space here trades a large flop record for
  // one simple next-state process.
  typedef struct packed {
    logic                                 sclkMeta;
    logic                                 sclkSync;
    logic                                 sclkLast;
    logic                                 selMeta;
    logic                                 selSync;
    logic                                 selLast;
    logic                                 sdiMeta;
    logic                                 sdiSync;
    spr_dev_e                             state;
    logic [4:0]                           bitCnt;
    logic [FRAME_BITS-1:0]                shiftIn;
    logic                                 isRead;
    logic [DATA_W-1:0]                    txShift;
    logic                                 serial_out;
    logic                                 sdoOe;
    logic [REG_COUNT-1:0][DATA_W-1:0]     mem;
    logic                                 wrStb;
    logic [ADDR_W-1:0]                    wrAddr;
    logic [DATA_W-1:0]                    wrData;
    logic [DATA_W-1:0]                    lookData;
  } spr_dev_s;

  // Frame fields; the commit path needs each of them twice.
  function automatic logic [ADDR_W-1:0] spr_addr_of(logic [FRAME_BITS-1:0] frame);
    return frame[FRAME_BITS-2:DATA_W];
  endfunction : spr_addr_of

  function automatic logic [DATA_W-1:0] spr_data_of(logic [FRAME_BITS-1:0] frame);
    return frame[DATA_W-1:0];
  endfunction : spr_data_of

  // Edge finders on a synchronised pin, older stage against newer stage.
  function automatic logic spr_rose(logic older, logic newer);
    return ~older & newer;
  endfunction : spr_rose

  function automatic logic spr_fell(logic older, logic newer);
    return older & ~newer;
  endfunction : spr_fell

  // Registered state and its next value.
  spr_dev_s q;
  spr_dev_s d;
  logic     sclkFall;
  logic     sclkRise;
  logic     selRise;
  logic     selected;
  logic [FRAME_BITS-1:0] nxtShift;

  // Edges are taken from the second and third stages only, so the first
  // stage of each synchroniser feeds nothing but the second.
  assign sclkFall = spr_fell(q.sclkLast, q.sclkSync);
  assign sclkRise = spr_rose(q.sclkLast, q.sclkSync);
  assign selRise  = spr_rose(q.selLast, q.selSync);
  assign selected = ~q.selSync;
  assign nxtShift = {q.shiftIn[FRAME_BITS-2:0], q.sdiSync};

  // Next-state logic for the whole port; the device never drives the clock
  // or the select, it only watches them.
  always_comb begin
    d          = q;
    // Three stages for clock and select, two for data; the data needs no
    // edge finder, so a third stage there would only add latency.
    d.sclkMeta = link.sclk;
    d.sclkSync = q.sclkMeta;
    d.sclkLast = q.sclkSync;
    d.selMeta  = link.portSelectN;
    d.selSync  = q.selMeta;
    d.selLast  = q.selSync;
    d.sdiMeta  = link.serialIn;
    d.sdiSync  = q.sdiMeta;

    d.wrStb    = 1'b0;
    // Local read port: one cycle from address to data.
    d.lookData = q.mem[lookAddr];

    // A high select wins over everything else, so a frame cut short can
    // never leave the output driven or a write half done.
    if (!selected || selRise) begin
      // Deselect throws away any partial frame and frees the output line.
      d.state   = DevIdle;
      d.bitCnt  = 5'h00;
      d.isRead  = 1'b0;
      d.sdoOe   = 1'b0;
      d.serial_out     = 1'b0;
    end else begin
      unique case (q.state)
        DevIdle: begin
          // Select has been seen low; wait for the first falling clock edge.
          d.state  = DevFrame;
          d.bitCnt = 5'h00;
          d.isRead = 1'b0;
        end
        DevFrame: begin
          // Input bits are taken on the falling edge only; a rise at most
          // moves the output.
          if (sclkFall) begin
            d.shiftIn = nxtShift;
            d.bitCnt  = q.bitCnt + 5'h01;
            if (q.bitCnt == CNT_ADDR_END) begin
              // Direction bit now sits above the seven address bits.
              d.isRead  = (nxtShift[ADDR_W] == DIR_READ);
              d.txShift = q.mem[nxtShift[ADDR_W-1:0]];
            end
            if (q.bitCnt == CNT_LAST) begin
              d.state = DevDone;
              if (!q.isRead) begin
                // Commit only when the sixteenth bit lands; a later write
                // to the same location simply overwrites an earlier one.
                d.mem[spr_addr_of(nxtShift)] = spr_data_of(nxtShift);
                d.wrStb  = 1'b1;
                d.wrAddr = spr_addr_of(nxtShift);
                d.wrData = spr_data_of(nxtShift);
              end
            end
          end else if (sclkRise && q.isRead && q.bitCnt >= CNT_DATA_BEG) begin
            // Output bits change only on the rise, so the master samples a
            // bit that has stood since three core cycles into the high half of the clock.
            d.serial_out     = q.txShift[DATA_W-1];
            d.txShift = {q.txShift[DATA_W-2:0], 1'b0};
            d.sdoOe   = 1'b1;
          end
        end
        DevDone: begin
          // Further clock edges are ignored until the select rises.
          d.state = DevDone;
        end
      endcase
    end
  end

  // Single state register; async reset loads constants only. The clock and
  // select stages start at their idle high level, so no false edge and no
  // false select follow the release of reset.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q          <= '0;
      q.sclkMeta <= 1'b1;
      q.sclkSync <= 1'b1;
      q.sclkLast <= 1'b1;
      q.selMeta  <= 1'b1;
      q.selSync  <= 1'b1;
      q.selLast  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Link pins; the enable falls once the select rises, so the shared line is
  // free whenever no frame runs.
  assign link.serialOut   = q.serial_out;
  assign link.serialOutOe = q.sdoOe;

  // Local ports, all straight from the state register.
  assign lookData         = q.lookData;
  assign wrStrobe         = q.wrStb;
  assign wrAddr           = q.wrAddr;
  assign wrData           = q.wrData;
endmodule : spr_device
`default_nettype wire

// >>> design/spr_pkg.sv
/*
 Shared constants for the serial register port: frame layout, register
 space size and the timing counts of both ends.
 Assumes a 100 MHz core clock at both ends.
*/
`default_nettype none
package spr_pkg;
  // Frame layout: one direction bit, seven address bits, eight data bits.
  localparam int          FRAME_BITS  = 16;
  localparam int          ADDR_W      = 7;
  localparam int          DATA_W      = 8;
  localparam int          REG_COUNT   = 128;
  localparam logic [4:0]  CNT_ADDR_END = 5'h07;
  localparam logic [4:0]  CNT_DATA_BEG = 5'h08;
  localparam logic [4:0]  CNT_LAST    = 5'h0f;
  localparam logic [4:0]  CNT_FULL    = 5'h10;
  localparam logic        DIR_WRITE   = 1'h0;
  localparam logic        DIR_READ    = 1'h1;

  // Core clock and serial clock made by the master.
  localparam int          CLK_MHZ       = 100;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          SCLK_PERIOD_NS = 160;
  localparam int          SCLK_HALF     = SCLK_PERIOD_NS / CLK_PERIOD_NS / 2;
  localparam logic [3:0]  DIV_LAST      = 4'(SCLK_HALF - 1);

  // Wait after reset before the first access, and spacing between accesses.
  localparam int          STARTUP_US     = 500;
  localparam int          STARTUP_CYCLES = STARTUP_US * CLK_MHZ;
  localparam int          MONITOR_KHZ    = 900;
  localparam int          CHARGER_KHZ    = 10;
  localparam int          GAP_CYCLES     = (CLK_MHZ * 1000 + CHARGER_KHZ - 1) / CHARGER_KHZ + 1;
  localparam int          WAIT_W         = 17;
endpackage : spr_pkg
`default_nettype wire

// >>> design/spr_if.sv
/*
 Carrier between the master end and the register port end.
 Assumes the bench resolves the shared serial output from its enable.
*/
`timescale 1ns/1ps
`default_nettype none
interface spr_if;
  logic sclk;         // Serial clock, idle high, made by the master.
  logic portSelectN;  // Port select, active low.
  logic serialIn;     // Master to device data.
  logic serialOut;    // Device to master data.
  logic serialOutOe;  // High while the device drives serialOut.

  modport device (input sclk, input portSelectN, input serialIn,
                  output serialOut, output serialOutOe);
  modport host (output sclk, output portSelectN, output serialIn,
                input serialOut);
endinterface : spr_if
`default_nettype wire

// >>> design/spr_host.sv
/*
 Master end: turns one request at a time into a sixteen-bit frame on the
 link, makes sclk from core_clk by a divider and returns read data.
 Assumes the device end meets the edge timing set by the divider.
*/
`timescale 1ns/1ps
`default_nettype none
module spr_host #(
  parameter int unsigned STARTUP_WAIT = spr_pkg::STARTUP_CYCLES,
  parameter int unsigned ACCESS_GAP   = spr_pkg::GAP_CYCLES
) (
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  spr_if.host                             link,
  input  wire logic                       reqValid,
  input  wire logic                       reqRead,
  input  wire logic [spr_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic [spr_pkg::DATA_W-1:0] reqData,
  output logic                            reqReady,
  output logic                            rspValid,
  output logic      [spr_pkg::DATA_W-1:0] rspData
);
  import spr_pkg::*;

  typedef enum logic [2:0] {HostWarm, HostIdle, HostSel, HostLow, HostHigh,
                            HostEnd, HostGap} spr_host_e;

  typedef struct packed {
    logic                  sdoMeta;
    logic                  sdoSync;
    logic [3:0]            divCnt;
    spr_host_e             state;
    logic [4:0]            bitCnt;
    logic [FRAME_BITS-1:0] txFrame;
    logic [DATA_W-1:0]     rxData;
    logic                  sclk;
    logic                  selN;
    logic                  serial_in;
    logic [WAIT_W-1:0]     waitCnt;
    logic                  ready;
    logic                  rspValid;
    logic [DATA_W-1:0]     rspData;
  } spr_host_s;

  spr_host_s q;
  spr_host_s d;
  logic      tick;

  // Half-period enable for the serial clock.
  assign tick = (q.divCnt == DIV_LAST);

  // Frame sequencer; the gap after every frame covers the slowest
  // register domain, so no access is ever swallowed by a later one.
  always_comb begin
    d          = q;
    d.sdoMeta  = link.serialOut;
    d.sdoSync  = q.sdoMeta;
    d.divCnt   = tick ? 4'h0 : q.divCnt + 4'h1;
    d.rspValid = 1'b0;
    unique case (q.state)
      HostWarm: begin
        d.waitCnt = q.waitCnt + WAIT_W'(1);
        if (q.waitCnt == WAIT_W'(STARTUP_WAIT - 1)) begin
          d.state = HostIdle;
          d.ready = 1'b1;
        end
      end
      HostIdle: begin
        if (reqValid) begin
          d.txFrame = {reqRead, reqAddr, reqRead ? 8'h00 : reqData};
          d.ready   = 1'b0;
          d.bitCnt  = 5'h00;
          d.state   = HostSel;
        end
      end
      HostSel: begin
        if (tick) begin
          d.selN  = 1'b0;
          d.serial_in   = q.txFrame[FRAME_BITS-1];
          d.state = HostLow;
        end
      end
      HostLow: begin
        if (tick) begin
          // The device shifts on the rise, so data is stable at the fall.
          d.sclk   = 1'b0;
          d.bitCnt = q.bitCnt + 5'h01;
          if (q.bitCnt >= CNT_DATA_BEG) begin
            d.rxData = {q.rxData[DATA_W-2:0], q.sdoSync};
          end
          d.state  = HostHigh;
        end
      end
      HostHigh: begin
        if (tick) begin
          d.sclk = 1'b1;
          if (q.bitCnt == CNT_FULL) begin
            d.state = HostEnd;
          end else begin
            d.txFrame = {q.txFrame[FRAME_BITS-2:0], 1'b0};
            d.serial_in     = q.txFrame[FRAME_BITS-2];
            d.state   = HostLow;
          end
        end
      end
      HostEnd: begin
        if (tick) begin
          d.selN     = 1'b1;
          d.rspValid = 1'b1;
          d.rspData  = q.rxData;
          d.waitCnt  = '0;
          d.state    = HostGap;
        end
      end
      HostGap: begin
        d.waitCnt = q.waitCnt + WAIT_W'(1);
        if (q.waitCnt == WAIT_W'(ACCESS_GAP - 1)) begin
          d.state = HostIdle;
          d.ready = 1'b1;
        end
      end
    endcase
  end

  // Reset leaves clock and select high, the idle levels of the link.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q      <= '0;
      q.sclk <= 1'b1;
      q.selN <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.sclk        = q.sclk;
  assign link.portSelectN = q.selN;
  assign link.serialIn    = q.serial_in;
  assign reqReady         = q.ready;
  assign rspValid         = q.rspValid;
  assign rspData          = q.rspData;
endmodule : spr_host
`default_nettype wire

// >>> tb/spr_link_checker.sv
/* Checker for the serial link between the master end and the device end.
   Assumes it sees the carrier signals of the link joining the two ends. */
`timescale 1ns/1ps
`default_nettype none
module spr_link_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic portSelectN,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutOe
);
  logic [4:0] fallCnt;
  logic       dirBit;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Counts sclk falls in a frame; the first fall carries the direction bit.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fallCnt <= 5'h00;
      dirBit  <= 1'h0;
    end else if (portSelectN) begin
      fallCnt <= 5'h00;
    end else if ($fell(sclk)) begin
      fallCnt <= fallCnt + 5'h01;
      if (fallCnt == 5'h00) dirBit <= serialIn;
    end
  end

  // Eight cycles of margin cover the select synchroniser in the device.
  chk_oe_released: assert property (portSelectN [*8] |-> !serialOutOe)
    else $error("serial output still driven after deselect");
  chk_sclk_idle: assert property (portSelectN |-> sclk)
    else $error("serial clock low while deselected");
  chk_low_half: assert property ($fell(sclk) |-> !sclk [*8] ##1 sclk)
    else $error("serial clock low phase not eight cycles");
  chk_high_half: assert property ($rose(sclk) |-> sclk [*8])
    else $error("serial clock high phase too short");
  chk_din_hold: assert property (!sclk && !$past(sclk) |-> $stable(serialIn))
    else $error("serial input moved while clock low");
  chk_dout_hold: assert property (!sclk [*5] |-> $stable(serialOut))
    else $error("serial output moved away from a rising clock");
  chk_sixteen_bits: assert property ($rose(portSelectN) |-> fallCnt == 5'h10)
    else $error("frame did not carry sixteen clocks");
  chk_read_drive: assert property ($rose(serialOutOe) |-> fallCnt == 5'h08 && dirBit)
    else $error("output enabled outside the read data phase");
  chk_write_quiet: assert property (!dirBit && fallCnt != 5'h00 |-> !serialOutOe)
    else $error("output enabled during a write frame");
endmodule : spr_link_checker
`default_nettype wire

// >>> tb/tb_spi_slave_register_port.sv
/* Bench for the serial register port: master and device on one link, and
   a second device driven by hand with broken frames.
   Assumes the package, carrier and both ends are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_spi_slave_register_port;
  import spr_pkg::*;
  logic       core_clk = 1'h0;
  logic       rstn;
  logic       reqValid;
  logic       reqRead;
  logic       reqReady;
  logic       rspValid;
  logic       wrStrobe;
  logic       wrStrobe2;
  logic [6:0] reqAddr;
  logic [6:0] lookAddr;
  logic [6:0] wrAddr;
  logic [7:0] reqData;
  logic [7:0] rspData;
  logic [7:0] lookData;
  logic [7:0] lookData2;
  logic [7:0] wrData;
  int         errors = 0;
  int         n_checks = 0;
  int         nWr = 0;
  int         nWr2 = 0;
  spr_if lk ();
  spr_if lk2 ();

  spr_host #(.STARTUP_WAIT(20), .ACCESS_GAP(10)) spr_host_inst (
    .core_clk(core_clk), .rstn(rstn), .link(lk), .reqValid(reqValid),
    .reqRead(reqRead), .reqAddr(reqAddr), .reqData(reqData),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData));
  spr_device spr_device_inst (
    .core_clk(core_clk), .rstn(rstn), .link(lk), .lookAddr(lookAddr),
    .lookData(lookData), .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData));
  if (1) begin : hand_side
    spr_device spr_device_inst (
      .core_clk(core_clk), .rstn(rstn), .link(lk2), .lookAddr(7'h11),
      .lookData(lookData2), .wrStrobe(wrStrobe2), .wrAddr(), .wrData());
  end
  spr_link_checker spr_link_checker_inst (
    .core_clk(core_clk), .rstn(rstn), .sclk(lk.sclk), .portSelectN(lk.portSelectN),
    .serialIn(lk.serialIn), .serialOut(lk.serialOut), .serialOutOe(lk.serialOutOe));

  // Core clock; write strobes are counted so lost or extra commits show up.
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (wrStrobe === 1'h1) nWr <= nWr + 1;
    if (wrStrobe2 === 1'h1) nWr2 <= nWr2 + 1;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  // One request through the master; waits are bounded so a hang shows as a miss.
  task automatic access(input logic rd, input logic [6:0] a, input logic [7:0] d);
    int k;
    for (k = 0; k < 99 && reqReady !== 1'h1; k++) @(negedge core_clk);
    @(posedge core_clk);
    reqValid <= 1'h1;
    reqRead  <= rd;
    reqAddr  <= a;
    reqData  <= d;
    @(posedge core_clk);
    reqValid <= 1'h0;
    for (k = 0; k < 400 && rspValid !== 1'h1; k++) @(negedge core_clk);
    check({6'h00, rspValid, reqReady}, 8'h02);
  endtask : access

  // Hand-made frame on the second link; the input is flipped once released.
  task automatic bang(input logic [15:0] f, input int n, input logic sel,
                      output logic [15:0] got);
    got = 16'h0000;
    @(posedge core_clk);
    lk2.portSelectN <= sel;
    for (int i = 0; i < n; i++) begin
      lk2.serialIn <= f[15 - i];
      repeat (8) @(posedge core_clk);
      got[15 - i] = lk2.serialOut;
      lk2.sclk <= 1'h0;
      repeat (8) @(posedge core_clk);
      lk2.sclk <= 1'h1;
    end
    repeat (8) @(posedge core_clk);
    lk2.portSelectN <= 1'h1;
    lk2.serialIn    <= ~lk2.serialIn;
    repeat (8) @(posedge core_clk);
  endtask : bang

  task automatic t_startup();
    repeat (10) @(negedge core_clk);
    check({7'h00, reqReady}, 8'h00);
  endtask : t_startup

  // System clock duty cycle: the high phase must lie within 30 to 70 percent.
  task automatic t_clock_duty();
    realtime tRise;
    int      hiNs;
    logic    dutyOk;
    @(posedge core_clk);
    tRise = $realtime;
    @(negedge core_clk);
    hiNs   = int'($realtime - tRise);
    dutyOk = (hiNs * 10 >= CLK_PERIOD_NS * 3) && (hiNs * 10 <= CLK_PERIOD_NS * 7);
    check({7'h00, dutyOk}, 8'h01);
  endtask : t_clock_duty

  // Writes at both ends of the space, then a second write to one address.
  task automatic t_write_read();
    logic [6:0] ad [4] = '{7'h00, 7'h7f, 7'h2a, 7'h2a};
    logic [7:0] dt [4] = '{8'ha5, 8'h3c, 8'h55, 8'hc3};
    for (int i = 0; i < 4; i++) begin
      access(DIR_WRITE, ad[i], dt[i]);
      check({1'h0, wrAddr}, {1'h0, ad[i]});
      check(wrData, dt[i]);
      check(8'(nWr), 8'(i + 1));
      @(posedge core_clk);
      lookAddr <= ad[i];
      repeat (2) @(negedge core_clk);
      check(lookData, dt[i]);
    end
    for (int i = 0; i < 4; i += (i == 1) ? 2 : 1) begin
      access(DIR_READ, ad[i], 8'h00);
      check(rspData, dt[i]);
    end
    check(8'(nWr), 8'h04);
  endtask : t_write_read

  // Clocks while deselected, a cut frame, then a full write and read back.
  task automatic t_abort();
    logic [15:0] got;
    bang({DIR_WRITE, 7'h11, 8'h99}, 16, 1'h1, got);
    bang({DIR_WRITE, 7'h11, 8'h99}, 10, 1'h0, got);
    check(8'(nWr2), 8'h00);
    check(lookData2, 8'h00);
    bang({DIR_WRITE, 7'h11, 8'h66}, 16, 1'h0, got);
    check(lookData2, 8'h66);
    bang({DIR_READ, 7'h11, 8'h00}, 16, 1'h0, got);
    check(got[7:0], 8'h66);
    check({7'h00, lk2.serialOutOe}, 8'h00);
  endtask : t_abort

  // Main sequence: reset for sixteen cycles, then every scenario in turn.
  initial begin
    rstn            = 1'h0;
    reqValid        = 1'h0;
    reqRead         = 1'h0;
    reqAddr         = 7'h00;
    reqData         = 8'h00;
    lookAddr        = 7'h00;
    lk2.sclk        = 1'h1;
    lk2.portSelectN = 1'h1;
    lk2.serialIn    = 1'h0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'h1;
    t_startup();
    t_clock_duty();
    t_write_read();
    t_abort();
    stop_test();
  end

  // Watchdog: the scenarios need well under a fifth of this span.
  initial begin
    #200000;
    errors++;
    stop_test();
  end
endmodule : tb_spi_slave_register_port
`default_nettype wire
